/* File: design/smbo_pkg.sv */
// Purpose: shared constants and types for the special-mode brake override supervisor
// Assumes: 125 MHz clock, one time base for the override interval
// Notes: the interval count is derived from minutes and the clock rate
package smbo_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned OVERRIDE_MINUTES = 15;
  localparam longint unsigned OVERRIDE_CYCLES = 64'(OVERRIDE_MINUTES) * 64'd60 * 64'(CLK_HZ);
  localparam int CNT_W = 37;
  localparam logic STATUS_FAIL = 1'b0;
  localparam logic STATUS_OK = 1'b1;

  typedef enum logic [1:0] {
    SMBO_IDLE,
    SMBO_ACTIVE,
    SMBO_SPENT
  } smbo_state_t;

  // start preconditions presented together by the surrounding safety logic
  typedef struct packed {
    logic commission_enable;
    logic brake_sys_on;
    logic op_mode_active;
    logic brake_check_running;
  } smbo_cond_t;

  // brake check status pair
  typedef struct packed {
    logic motor_ok;
    logic redundant_ok;
  } smbo_brake_t;
endpackage

/* File: design/smbo_override.sv */
// Purpose: supervisor of the one-time special-mode enabling without valid brake status
// Assumes: all inputs synchronous to CLOCK; RST asserted at control-voltage power-up
// Notes: brake check sequencing and the warning timeline live outside this block
`timescale 1ns/1ns

// Function
// - override accepted once per power-up only
// - start needs brake system switched on
// - start needs at least one brake unsuccessful
// - start needs operating mode active
// - start refused while brake check runs
// - start needs commissioning enable
// - valid start sets both statuses successful
// - valid start loads fifteen minutes remaining
// - override diag replaces interval prewarning
// - special mode acknowledged while override runs
// - missing-check error clearable during override
// - redundant brake circuit fault ends enabling
// - timeout ends enabling, raises interval error
// - termination returns both statuses unsuccessful
// - power-up initialises both statuses unsuccessful
// - brake check accepted only normal op, enable
module smbo_override #(
  parameter longint unsigned OVERRIDE_CYCLES = smbo_pkg::OVERRIDE_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic START_REQ,
  input wire logic TERMINATE_REQ,
  input wire smbo_pkg::smbo_cond_t COND,
  input wire logic REDUNDANT_CIRCUIT_FAULT,
  input wire logic BRAKE_CHECK_REQ,
  input wire logic NORMAL_OP,
  input wire logic DRIVE_ENABLE,
  input wire logic BRAKE_CHECK_DONE_OK,
  input wire logic PREWARNING_IN,
  input wire logic MISSING_ERROR_IN,
  input wire logic MISSING_ERROR_CLEAR_REQ,
  output logic OVERRIDE_ACTIVE,
  output smbo_pkg::smbo_brake_t BRAKE_STATUS,
  output logic [smbo_pkg::CNT_W-1:0] REMAINING_CYCLES,
  output logic NOT_EXECUTABLE_DIAG,
  output logic OVERRIDE_DIAG,
  output logic INTERVAL_PREWARNING,
  output logic SPECIAL_MODE_ACK,
  output logic MISSING_ERROR_CLEAR,
  output logic INTERVAL_EXCEEDED_ERROR,
  output logic BRAKE_CHECK_ACCEPT
);
  localparam logic [smbo_pkg::CNT_W-1:0] LOAD_CYCLES = OVERRIDE_CYCLES[smbo_pkg::CNT_W-1:0];

  smbo_pkg::smbo_state_t state_reg, state_next;
  smbo_pkg::smbo_brake_t status_reg, status_next;
  logic [smbo_pkg::CNT_W-1:0] remain_reg, remain_next;
  logic used_reg;
  logic diag_reg;
  logic exceeded_reg;

  wire logic any_unsuccessful = ~status_reg.motor_ok | ~status_reg.redundant_ok;
  wire logic conds_ok = COND.commission_enable
    & COND.brake_sys_on
    & any_unsuccessful
    & COND.op_mode_active
    & ~COND.brake_check_running
    & ~used_reg;
  wire logic is_idle = (state_reg == smbo_pkg::SMBO_IDLE) | (state_reg == smbo_pkg::SMBO_SPENT);
  wire logic start_ok = START_REQ & is_idle & conds_ok;
  wire logic start_bad = START_REQ & is_idle & ~conds_ok;
  wire logic active = (state_reg == smbo_pkg::SMBO_ACTIVE);
  wire logic timeout = active & (remain_reg <= {{(smbo_pkg::CNT_W-1){1'b0}}, 1'b1});
  wire logic ends = active & (TERMINATE_REQ | REDUNDANT_CIRCUIT_FAULT | timeout);

  always_comb
  begin
    state_next = state_reg;
    status_next = status_reg;
    remain_next = remain_reg;
    unique case (state_reg)
      smbo_pkg::SMBO_IDLE, smbo_pkg::SMBO_SPENT:
      begin
        if (start_ok)
        begin
          state_next = smbo_pkg::SMBO_ACTIVE;
          status_next = '{smbo_pkg::STATUS_OK, smbo_pkg::STATUS_OK};
          remain_next = LOAD_CYCLES;
        end
        // a refused start in the same cycle must leave the statuses alone
        else if (BRAKE_CHECK_ACCEPT & BRAKE_CHECK_DONE_OK & ~START_REQ)
        begin
          status_next = '{smbo_pkg::STATUS_OK, smbo_pkg::STATUS_OK};
        end
      end
      smbo_pkg::SMBO_ACTIVE:
      begin
        remain_next = remain_reg - {{(smbo_pkg::CNT_W-1){1'b0}}, 1'b1};
        if (ends)
        begin
          // fault, timeout and termination all end the override and drop the statuses
          state_next = smbo_pkg::SMBO_SPENT;
          status_next = '{smbo_pkg::STATUS_FAIL, smbo_pkg::STATUS_FAIL};
          remain_next = '0;
        end
      end
      default:
      begin
        state_next = smbo_pkg::SMBO_SPENT;
        status_next = '{smbo_pkg::STATUS_FAIL, smbo_pkg::STATUS_FAIL};
      end
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      state_reg <= smbo_pkg::SMBO_IDLE;
      status_reg <= '{smbo_pkg::STATUS_FAIL, smbo_pkg::STATUS_FAIL};
      remain_reg <= '0;
      used_reg <= 1'b0;
      diag_reg <= 1'b0;
      exceeded_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      status_reg <= status_next;
      remain_reg <= remain_next;
      used_reg <= used_reg | start_ok;
      diag_reg <= start_bad;
      // sticky until power-up: the error must outlive the override that caused it
      exceeded_reg <= exceeded_reg | timeout;
    end
  end

  assign OVERRIDE_ACTIVE = active;
  assign BRAKE_STATUS = status_reg;
  assign REMAINING_CYCLES = remain_reg;
  assign NOT_EXECUTABLE_DIAG = diag_reg;
  assign OVERRIDE_DIAG = active;
  assign INTERVAL_PREWARNING = PREWARNING_IN & ~active;
  assign SPECIAL_MODE_ACK = active;
  assign MISSING_ERROR_CLEAR = active & MISSING_ERROR_IN & MISSING_ERROR_CLEAR_REQ;
  assign INTERVAL_EXCEEDED_ERROR = exceeded_reg;
  // the partner must have ended the override first; a running override blocks the check
  assign BRAKE_CHECK_ACCEPT = BRAKE_CHECK_REQ & NORMAL_OP & DRIVE_ENABLE & ~active;

  sequence s_start;
    START_REQ & is_idle & conds_ok;
  endsequence

  sequence s_running;
    OVERRIDE_ACTIVE & BRAKE_STATUS.motor_ok & BRAKE_STATUS.redundant_ok;
  endsequence

  sequence s_refused;
    !OVERRIDE_ACTIVE && NOT_EXECUTABLE_DIAG;
  endsequence

  sequence s_ended;
    !OVERRIDE_ACTIVE && !BRAKE_STATUS.motor_ok && !BRAKE_STATUS.redundant_ok;
  endsequence

  property p_once;
    @(posedge CLOCK) disable iff (RST)
    used_reg |-> ##1 !($rose(OVERRIDE_ACTIVE));
  endproperty
  a_once: assert property (p_once) else $error("override restarted after power-up");

  property p_conds;
    @(posedge CLOCK) disable iff (RST)
    $rose(OVERRIDE_ACTIVE) |-> $past(COND.commission_enable) && $past(COND.brake_sys_on)
      && $past(COND.op_mode_active) && !$past(COND.brake_check_running);
  endproperty
  a_conds: assert property (p_conds) else $error("override started without preconditions");

  property p_unsucc;
    @(posedge CLOCK) disable iff (RST)
    $rose(OVERRIDE_ACTIVE) |-> !($past(BRAKE_STATUS.motor_ok) && $past(BRAKE_STATUS.redundant_ok));
  endproperty
  a_unsucc: assert property (p_unsucc) else $error("override started with valid statuses");

  property p_refuse;
    @(posedge CLOCK) disable iff (RST)
    (START_REQ && is_idle && !conds_ok) |=> NOT_EXECUTABLE_DIAG && $stable(BRAKE_STATUS);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused start not reported");

  property p_start;
    @(posedge CLOCK) disable iff (RST)
    s_start |=> s_running and (REMAINING_CYCLES == LOAD_CYCLES);
  endproperty
  a_start: assert property (p_start) else $error("valid start did not load override");

  property p_prewarn;
    @(posedge CLOCK) disable iff (RST)
    OVERRIDE_ACTIVE |-> !INTERVAL_PREWARNING && OVERRIDE_DIAG && SPECIAL_MODE_ACK;
  endproperty
  a_prewarn: assert property (p_prewarn) else $error("prewarning shown during override");

  property p_fault;
    @(posedge CLOCK) disable iff (RST)
    (OVERRIDE_ACTIVE && REDUNDANT_CIRCUIT_FAULT) |=> !OVERRIDE_ACTIVE && !SPECIAL_MODE_ACK;
  endproperty
  a_fault: assert property (p_fault) else $error("fault did not end enabling");

  property p_timeout;
    @(posedge CLOCK) disable iff (RST)
    (OVERRIDE_ACTIVE && REMAINING_CYCLES == 1) |=> !OVERRIDE_ACTIVE && INTERVAL_EXCEEDED_ERROR;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not handled");

  property p_end;
    @(posedge CLOCK) disable iff (RST)
    $fell(OVERRIDE_ACTIVE) |-> !BRAKE_STATUS.motor_ok && !BRAKE_STATUS.redundant_ok;
  endproperty
  a_end: assert property (p_end) else $error("statuses valid after termination");

  property p_check;
    @(posedge CLOCK) disable iff (RST)
    BRAKE_CHECK_ACCEPT |-> NORMAL_OP && DRIVE_ENABLE && !OVERRIDE_ACTIVE;
  endproperty
  a_check: assert property (p_check) else $error("brake check accepted illegally");

  property p_enable;
    @(posedge CLOCK) disable iff (RST)
    (START_REQ && is_idle && !COND.commission_enable) |=> s_refused;
  endproperty
  a_enable: assert property (p_enable) else $error("start ran without enable");

  property p_sys_off;
    @(posedge CLOCK) disable iff (RST)
    (START_REQ && is_idle && !COND.brake_sys_on) |=> s_refused;
  endproperty
  a_sys_off: assert property (p_sys_off) else $error("start ran, brake system off");

  property p_mode_off;
    @(posedge CLOCK) disable iff (RST)
    (START_REQ && is_idle && !COND.op_mode_active) |=> s_refused;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("start ran, mode inactive");

  property p_busy;
    @(posedge CLOCK) disable iff (RST)
    (START_REQ && is_idle && COND.brake_check_running) |=> s_refused;
  endproperty
  a_busy: assert property (p_busy) else $error("start ran during brake check");

  property p_spent;
    @(posedge CLOCK) disable iff (RST)
    (START_REQ && state_reg == smbo_pkg::SMBO_SPENT) |=> s_refused;
  endproperty
  a_spent: assert property (p_spent) else $error("second start accepted");

  property p_count;
    @(posedge CLOCK) disable iff (RST)
    (OVERRIDE_ACTIVE && !ends)
      |=> REMAINING_CYCLES + {{(smbo_pkg::CNT_W-1){1'b0}}, 1'b1} == $past(REMAINING_CYCLES);
  endproperty
  a_count: assert property (p_count) else $error("interval count skipped");

  property p_hold;
    @(posedge CLOCK) disable iff (RST)
    (OVERRIDE_ACTIVE && !ends) |=> s_running;
  endproperty
  a_hold: assert property (p_hold) else $error("statuses dropped during override");

  property p_limit;
    @(posedge CLOCK) disable iff (RST)
    OVERRIDE_ACTIVE |-> REMAINING_CYCLES != '0 && REMAINING_CYCLES <= LOAD_CYCLES;
  endproperty
  a_limit: assert property (p_limit) else $error("override beyond its interval");

  property p_terminate;
    @(posedge CLOCK) disable iff (RST)
    (OVERRIDE_ACTIVE && TERMINATE_REQ) |=> s_ended;
  endproperty
  a_terminate: assert property (p_terminate) else $error("termination left override on");

  property p_sticky;
    @(posedge CLOCK) disable iff (RST)
    INTERVAL_EXCEEDED_ERROR |=> INTERVAL_EXCEEDED_ERROR;
  endproperty
  a_sticky: assert property (p_sticky) else $error("interval error lost");

  property p_idle_ack;
    @(posedge CLOCK) disable iff (RST)
    !OVERRIDE_ACTIVE |-> !SPECIAL_MODE_ACK && !OVERRIDE_DIAG;
  endproperty
  a_idle_ack: assert property (p_idle_ack) else $error("special mode acked while idle");

  property p_prewarn_pass;
    @(posedge CLOCK) disable iff (RST)
    (!OVERRIDE_ACTIVE && PREWARNING_IN) |-> INTERVAL_PREWARNING;
  endproperty
  a_prewarn_pass: assert property (p_prewarn_pass) else $error("prewarning lost");

  property p_clear_on;
    @(posedge CLOCK) disable iff (RST)
    (OVERRIDE_ACTIVE && MISSING_ERROR_IN && MISSING_ERROR_CLEAR_REQ) |-> MISSING_ERROR_CLEAR;
  endproperty
  a_clear_on: assert property (p_clear_on) else $error("missing error not cleared");

  property p_clear_off;
    @(posedge CLOCK) disable iff (RST)
    !OVERRIDE_ACTIVE |-> !MISSING_ERROR_CLEAR;
  endproperty
  a_clear_off: assert property (p_clear_off) else $error("error cleared while idle");

  property p_reset;
    @(posedge CLOCK)
    RST |=> !OVERRIDE_ACTIVE && !BRAKE_STATUS.motor_ok && !BRAKE_STATUS.redundant_ok
      && !INTERVAL_EXCEEDED_ERROR && !NOT_EXECUTABLE_DIAG;
  endproperty
  a_reset: assert property (p_reset) else $error("power-up state wrong");

  property p_check_ok;
    @(posedge CLOCK) disable iff (RST)
    (BRAKE_CHECK_ACCEPT && BRAKE_CHECK_DONE_OK && !START_REQ)
      |=> BRAKE_STATUS.motor_ok && BRAKE_STATUS.redundant_ok;
  endproperty
  a_check_ok: assert property (p_check_ok) else $error("passed brake check lost");
endmodule

/* File: tb/smbo_operator.sv */
// Purpose: operator model issuing override and brake check commands
// Assumes: bench commands already change at the falling edge
// Notes: check request held back while the override runs
`timescale 1ns/1ns
module smbo_operator (
  input wire logic start_cmd,
  input wire logic term_cmd,
  input wire logic check_cmd,
  input wire logic override_active,
  output logic start_req,
  output logic term_req,
  output logic check_req
);
  assign start_req = start_cmd;
  assign term_req = term_cmd;
  // override must end first, so a check asked for too early waits
  assign check_req = check_cmd & ~override_active;
endmodule

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of the override supervisor
// Assumes: short override count so timeout fits the run
// Notes: random traffic on prewarning and clear inputs
`timescale 1ns/1ns
module tb_top;
  localparam int N = 20;
  logic clk, rst, s_c, t_c, c_c, s_r, t_r, c_r, flt, nop, den, dok, pw, ms, cr;
  logic act, ne, od, pwo, ack, clo, exc, acc;
  smbo_pkg::smbo_cond_t cond;
  smbo_pkg::smbo_brake_t st;
  logic [smbo_pkg::CNT_W-1:0] rem;
  int num_errors = 0;
  int cmp_count = 0;
  int seed = 32'h8829d003;
  int k;
  smbo_operator op (.start_cmd(s_c), .term_cmd(t_c), .check_cmd(c_c),
    .override_active(act), .start_req(s_r), .term_req(t_r), .check_req(c_r));
  smbo_override #(.OVERRIDE_CYCLES(N)) uut (.CLOCK(clk), .RST(rst), .START_REQ(s_r),
    .TERMINATE_REQ(t_r), .COND(cond), .REDUNDANT_CIRCUIT_FAULT(flt),
    .BRAKE_CHECK_REQ(c_r), .NORMAL_OP(nop), .DRIVE_ENABLE(den),
    .BRAKE_CHECK_DONE_OK(dok), .PREWARNING_IN(pw), .MISSING_ERROR_IN(ms),
    .MISSING_ERROR_CLEAR_REQ(cr), .OVERRIDE_ACTIVE(act), .BRAKE_STATUS(st),
    .REMAINING_CYCLES(rem), .NOT_EXECUTABLE_DIAG(ne), .OVERRIDE_DIAG(od),
    .INTERVAL_PREWARNING(pwo), .SPECIAL_MODE_ACK(ack), .MISSING_ERROR_CLEAR(clo),
    .INTERVAL_EXCEEDED_ERROR(exc), .BRAKE_CHECK_ACCEPT(acc));
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  function automatic logic e_pw(input logic p, input logic a);
    return p & ~a;
  endfunction
  function automatic logic e_clr(input logic a, input logic m, input logic c);
    return a & m & c;
  endfunction
  task automatic chk(input string n, input logic [36:0] e, input logic [36:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rst_dut;
    rst = 1;
    cyc(3);
    rst = 0;
  endtask
  task automatic go;
    s_c = 1;
    cyc(1);
    s_c = 0;
  endtask
  task automatic test_done;
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    {rst, s_c, t_c, c_c, flt, dok, pw, ms, cr} = 9'h100;
    {nop, den} = 2'h3;
    cond = 4'hE;
    cyc(3);
    rst = 0;
    chk("status", 2'h0, st);
    c_c = 1;
    nop = 0;
    #1 chk("accept", 1'h0, acc);
    cyc(1);
    {nop, dok} = 2'h3;
    #1 chk("accept", 1'h1, acc);
    cyc(1);
    {c_c, dok} = 2'h0;
    go();
    chk("diag", 1'h1, ne);
    rst_dut();
    for (int i = 0; i < 4; i++)
    begin
      cond = 4'hE ^ (4'h8 >> i);
      go();
      chk("diag", 1'h1, ne);
      chk("status", 2'h0, st);
      cyc(1);
    end
    cond = 4'hE;
    go();
    chk("status", 2'h3, st);
    chk("remain", N, rem);
    chk("ack", 1'h1, ack);
    chk("ovdiag", 1'h1, od);
    for (int i = 0; i < 8; i++)
    begin
      {pw, ms, cr} = 3'($random(seed));
      #1 chk("prewarn", e_pw(pw, 1'b1), pwo);
      chk("clear", e_clr(1'b1, ms, cr), clo);
      chk("remain", N - i, rem);
      cyc(1);
    end
    t_c = 1;
    cyc(1);
    t_c = 0;
    chk("status", 2'h0, st);
    chk("prewarn", e_pw(pw, 1'b0), pwo);
    chk("clear", e_clr(1'b0, ms, cr), clo);
    chk("ack", 1'h0, ack);
    go();
    chk("active", 1'h0, act);
    chk("diag", 1'h1, ne);
    rst_dut();
    go();
    for (k = 0; k < N + 5 && act === 1'b1; k++)
      cyc(1);
    chk("cycles", N, k);
    chk("exceeded", 1'h1, exc);
    chk("ack", 1'h0, ack);
    rst_dut();
    go();
    flt = 1;
    cyc(1);
    chk("active", 1'h0, act);
    chk("status", 2'h0, st);
    chk("exceeded", 1'h0, exc);
    test_done();
  end
endmodule
